// ### design/chg_pkg.sv
// Behaviour
// [RULE_01] Temperature outside window while charging suspends charge and freezes the timer.
// [RULE_02] Temperature back in window resumes the suspended phase with the held timer.
// [RULE_03] Sense input near supply with no battery enters regulator test mode.
// [RULE_04] Test mode ends when the sense input is released or power cycles.
// [RULE_05] Thermistor bias is off in shutdown, standby and test mode.
// [RULE_06] Sense pull-down is on only in standby and test mode.
// [RULE_07] Status pins only sink or float, never drive high.
// [RULE_08] Status pins encode shutdown, standby, faults, charging, complete and test mode.
// [RULE_09] Supply-good is low when supply is above lockout and battery voltage.
// [RULE_10] Supply-good toggles while supply is below regulation plus offset.
// [RULE_11] Safety timer runs while the active-low timer enable is low.
// [RULE_12] Open or high current-set pin disables the charger and ends charging.
// [RULE_13] Restoring a valid current-set resistance starts a new charge cycle.
// [RULE_14] Timer expiry in fast charge latches a timer fault until cleared.
// [RULE_15] The safety timer is cleared on every entry to constant current; the code keeps the held count on a resume from temperature fault.
// [RULE_16] End-of-charge current must persist through the filter interval.
// [RULE_17] In charge complete, a battery fall below recharge restarts charging.
// [RULE_18] Inputs are synchronised, lockout wins, outputs change on registered state.
package chg_pkg;
  localparam int CLK_MHZ = 100;
  localparam int EOC_FILTER_US = 1000;
  localparam int EOC_FILTER_CYC = EOC_FILTER_US * CLK_MHZ;
  localparam int MS_TICK_US = 1000;
  localparam int MS_TICK_CYC = MS_TICK_US * CLK_MHZ;
  localparam int SAFETY_TIME_MIN = 360;
  localparam int SAFETY_TIME_MS = SAFETY_TIME_MIN * 60000;
  localparam int PROBE_HALF_MS = 100;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STAT = 8'h08;
  localparam logic [7:0] OFS_INT_CLR = 8'h0c;
  localparam logic [7:0] OFS_INT_EN = 8'h10;
  localparam logic [7:0] OFS_TIMER = 8'h14;
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int CTRL_TIMER_OFF_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [4:0] INT_EN_RESET = 5'h00;
  localparam int EV_STATE_BIT = 0;
  localparam int EV_TEMP_BIT = 1;
  localparam int EV_TIMER_BIT = 2;
  localparam int EV_DONE_BIT = 3;
  localparam int EV_TEST_BIT = 4;
  localparam int NUM_EV = 5;
  localparam int NUM_SYNC = 15;
  typedef enum logic [3:0] {
    ST_SHUTDOWN, ST_STANDBY, ST_PRECOND, ST_FAST, ST_CONSTV,
    ST_COMPLETE, ST_TEMP_FAULT, ST_TIMER_FAULT, ST_TEST
  } chg_state_t;
endpackage

// ### design/chg_ctrl.sv
module chg_ctrl
  import chg_pkg::*;
#(
  parameter int EOC_FILTER_CYCLES = EOC_FILTER_CYC,
  parameter int MS_CYCLES = MS_TICK_CYC,
  parameter int SAFETY_MS = SAFETY_TIME_MS
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic supply_lockout,
  input wire logic supply_above_bat,
  input wire logic supply_above_reg,
  input wire logic temp_in_window,
  input wire logic temp_test_level,
  input wire logic battery_present,
  input wire logic current_set_pin,
  input wire logic bat_below_precond,
  input wire logic bat_at_reg,
  input wire logic eoc_current,
  input wire logic bat_below_recharge,
  input wire logic timer_enable_n,
  input wire logic status_out_a_i,
  input wire logic status_out_b_i,
  input wire logic supply_good_n_i,
  output logic status_out_a_o,
  output logic status_out_a_oe,
  output logic status_out_b_o,
  output logic status_out_b_oe,
  output logic supply_good_n_o,
  output logic supply_good_n_oe,
  output logic pass_enable,
  output logic precondition_mode,
  output logic regulator_mode,
  output logic thermistor_bias_current,
  output logic temp_pulldown,
  output logic irq
);

  // Three-stage synchroniser for every pin and comparator input.
  logic [NUM_SYNC-1:0] raw;
  logic [NUM_SYNC-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
  assign raw = {supply_lockout, supply_above_bat, supply_above_reg, temp_in_window,
                temp_test_level, battery_present, current_set_pin, bat_below_precond,
                bat_at_reg, eoc_current, bat_below_recharge, timer_enable_n,
                status_out_a_i, status_out_b_i, supply_good_n_i};

  // A level is accepted once the second and third stages agree.
  always_comb
  begin
    for (int i = 0; i < NUM_SYNC; i++)
    begin
      flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i]; // [RULE_18]
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 15'h0007;
      s2_q <= 15'h0007;
      s3_q <= 15'h0007;
      flt_q <= 15'h0007;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      flt_q <= flt_d;
    end
  end

  logic lockout, above_bat, above_reg, in_window, test_level, bat_present;
  logic set_open, below_pre, at_reg, eoc_raw, below_rech, tmr_en_n;
  logic [2:0] pin_level;
  assign {lockout, above_bat, above_reg, in_window, test_level, bat_present, set_open,
          below_pre, at_reg, eoc_raw, below_rech, tmr_en_n, pin_level} = flt_q;

  // Millisecond tick, end-of-charge filter and safety timer.
  logic [31:0] div_q, div_d, eoc_cnt_q, eoc_cnt_d, tmr_q, tmr_d;
  logic [7:0] probe_cnt_q, probe_cnt_d;
  logic probe_q, probe_d, tick, eoc_ok, tmr_run, tmr_expired;
  logic [1:0] ctrl_q, ctrl_d;
  chg_state_t st_q, st_d, resume_q, resume_d;

  assign tick = (div_q == 32'(MS_CYCLES - 1));
  assign eoc_ok = (eoc_cnt_q >= 32'(EOC_FILTER_CYCLES)); // [RULE_16]
  assign tmr_expired = (tmr_q >= 32'(SAFETY_MS));
  // The timer counts only in active charge phases and only while enabled.
  assign tmr_run = !tmr_en_n && !ctrl_q[CTRL_TIMER_OFF_BIT] && // [RULE_11]
                   (st_q == ST_PRECOND || st_q == ST_FAST || st_q == ST_CONSTV);

  always_comb
  begin
    div_d = tick ? 32'h0 : div_q + 32'h1;
    eoc_cnt_d = (eoc_raw && st_q == ST_CONSTV) ? (eoc_ok ? eoc_cnt_q : eoc_cnt_q + 32'h1)
                                                 : 32'h0; // [RULE_16]
    tmr_d = tmr_q;
    if ((st_d == ST_FAST && st_q != ST_FAST && st_q != ST_TEMP_FAULT) ||
        st_q == ST_STANDBY || st_q == ST_SHUTDOWN)
    begin
      tmr_d = 32'h0; // [RULE_15]
    end
    else if (tmr_run && tick && !tmr_expired)
    begin
      tmr_d = tmr_q + 32'h1; // [RULE_01] [RULE_11]
    end
    probe_cnt_d = probe_cnt_q;
    probe_d = probe_q;
    if (!lockout && !above_reg)
    begin
      if (tick)
      begin
        probe_cnt_d = (probe_cnt_q == 8'(PROBE_HALF_MS - 1)) ? 8'h0 : probe_cnt_q + 8'h1;
        probe_d = (probe_cnt_q == 8'(PROBE_HALF_MS - 1)) ? !probe_q : probe_q; // [RULE_10]
      end
    end
    else
    begin
      probe_cnt_d = 8'h0;
      probe_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_q <= 32'h0;
      eoc_cnt_q <= 32'h0;
      tmr_q <= 32'h0;
      probe_cnt_q <= 8'h0;
      probe_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      eoc_cnt_q <= eoc_cnt_d;
      tmr_q <= tmr_d;
      probe_cnt_q <= probe_cnt_d;
      probe_q <= probe_d;
    end
  end

  // Charge state machine; lockout overrides every other condition.
  logic disabled;
  assign disabled = set_open || ctrl_q[CTRL_INHIBIT_BIT]; // [RULE_12]

  always_comb
  begin
    st_d = st_q;
    resume_d = resume_q;
    if (lockout || !above_bat)
    begin
      st_d = ST_SHUTDOWN; // [RULE_18] [RULE_04]
    end
    else
    begin
      case (st_q)
        ST_SHUTDOWN: st_d = ST_STANDBY;
        ST_STANDBY:
        begin
          if (test_level && !bat_present)
            st_d = ST_TEST; // [RULE_03]
          else if (bat_present && !disabled)
            st_d = below_pre ? ST_PRECOND : ST_FAST; // [RULE_13]
        end
        ST_TEST:
        begin
          if (!test_level)
            st_d = ST_STANDBY; // [RULE_04]
        end
        ST_PRECOND, ST_FAST, ST_CONSTV:
        begin
          if (disabled || !bat_present)
            st_d = ST_STANDBY; // [RULE_12]
          else if (!in_window)
          begin
            st_d = ST_TEMP_FAULT; // [RULE_01]
            resume_d = st_q;
          end
          else if (st_q == ST_PRECOND && !below_pre)
            st_d = ST_FAST;
          else if (st_q == ST_FAST && tmr_expired)
            st_d = ST_TIMER_FAULT; // [RULE_14]
          else if (st_q == ST_FAST && at_reg)
            st_d = ST_CONSTV;
          else if (st_q == ST_CONSTV && (eoc_ok || tmr_expired))
            st_d = ST_COMPLETE; // [RULE_16]
        end
        ST_TEMP_FAULT:
        begin
          if (disabled || !bat_present)
            st_d = ST_STANDBY;
          else if (in_window)
            st_d = resume_q; // [RULE_02]
        end
        ST_TIMER_FAULT:
        begin
          if (disabled || !bat_present)
            st_d = ST_STANDBY; // [RULE_14]
        end
        ST_COMPLETE:
        begin
          if (disabled || !bat_present)
            st_d = ST_STANDBY;
          else if (below_rech)
            st_d = ST_FAST; // [RULE_17]
        end
        default: st_d = ST_SHUTDOWN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= ST_SHUTDOWN;
      resume_q <= ST_FAST;
    end
    else
    begin
      st_q <= st_d;
      resume_q <= resume_d;
    end
  end

  // Pin and analog-control outputs, decoded from the registered state.
  logic sa_low, sb_low, pg_low;
  always_comb
  begin
    sa_low = (st_q == ST_PRECOND || st_q == ST_FAST || st_q == ST_CONSTV ||
              st_q == ST_TEST); // [RULE_08]
    sb_low = (st_q == ST_COMPLETE || st_q == ST_TEST); // [RULE_08]
    pg_low = (st_q != ST_SHUTDOWN) && !probe_q; // [RULE_09] [RULE_10]
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      status_out_a_oe <= 1'b0;
      status_out_b_oe <= 1'b0;
      supply_good_n_oe <= 1'b0;
      pass_enable <= 1'b0;
      precondition_mode <= 1'b0;
      regulator_mode <= 1'b0;
      thermistor_bias_current <= 1'b0;
      temp_pulldown <= 1'b0;
    end
    else
    begin
      status_out_a_oe <= sa_low; // [RULE_18]
      status_out_b_oe <= sb_low;
      supply_good_n_oe <= pg_low;
      pass_enable <= (st_q == ST_PRECOND || st_q == ST_FAST || st_q == ST_CONSTV); // [RULE_01]
      precondition_mode <= (st_q == ST_PRECOND);
      regulator_mode <= (st_q == ST_TEST); // [RULE_03]
      thermistor_bias_current <= !(st_q == ST_SHUTDOWN || st_q == ST_STANDBY ||
                                   st_q == ST_TEST); // [RULE_05]
      temp_pulldown <= (st_q == ST_STANDBY || st_q == ST_TEST); // [RULE_06]
    end
  end

  // Open-drain data is a constant low; only the enables move.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      status_out_a_o <= 1'b0;
      status_out_b_o <= 1'b0;
      supply_good_n_o <= 1'b0;
    end
    else
    begin
      status_out_a_o <= 1'b0; // [RULE_07]
      status_out_b_o <= 1'b0;
      supply_good_n_o <= 1'b0;
    end
  end

  // Interrupt events, taken from state transitions.
  logic [NUM_EV-1:0] ev, int_stat_q, int_stat_d, int_en_q, int_en_d, clr;
  logic irq_d;
  always_comb
  begin
    ev = '0;
    ev[EV_STATE_BIT] = (st_d != st_q);
    ev[EV_TEMP_BIT] = (st_d == ST_TEMP_FAULT) && (st_q != ST_TEMP_FAULT);
    ev[EV_TIMER_BIT] = (st_d == ST_TIMER_FAULT) && (st_q != ST_TIMER_FAULT);
    ev[EV_DONE_BIT] = (st_d == ST_COMPLETE) && (st_q != ST_COMPLETE);
    ev[EV_TEST_BIT] = (st_d == ST_TEST) && (st_q != ST_TEST);
  end

  // Bus slave: address phase latched, zero wait states, always OKAY.
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_d;
  logic access;
  assign access = hsel && htrans[1] && hready;

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a == OFS_CTRL)
      v = {30'h0, ctrl_q};
    else if (a == OFS_STATUS)
      v = {13'h0, pin_level, flt_q[14:3], st_q};
    else if (a == OFS_INT_STAT)
      v = {27'h0, int_stat_q};
    else if (a == OFS_INT_EN)
      v = {27'h0, int_en_q};
    else if (a == OFS_TIMER)
      v = tmr_q;
    return v;
  endfunction

  always_comb
  begin
    wr_pend_d = access && hwrite;
    wr_addr_d = access ? haddr[7:0] : wr_addr_q;
    rdata_d = (access && !hwrite) ? reg_read(haddr[7:0]) : 32'h0;
    ctrl_d = ctrl_q;
    int_en_d = int_en_q;
    clr = '0;
    if (wr_pend_q)
    begin
      if (wr_addr_q == OFS_CTRL)
        ctrl_d = hwdata[1:0];
      else if (wr_addr_q == OFS_INT_EN)
        int_en_d = hwdata[NUM_EV-1:0];
      else if (wr_addr_q == OFS_INT_CLR)
        clr = hwdata[NUM_EV-1:0];
    end
    int_stat_d = (int_stat_q & ~clr) | ev;
    irq_d = |(int_stat_d & int_en_d);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_q <= CTRL_RESET;
      int_en_q <= INT_EN_RESET;
      int_stat_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      hrdata <= rdata_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_q <= ctrl_d;
      int_en_q <= int_en_d;
      int_stat_q <= int_stat_d;
      irq <= irq_d;
    end
  end

endmodule

// ### sim/chg_batt_model.sv
module chg_batt_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pass_enable,
  input wire logic precondition_mode,
  input wire logic stall,
  input wire logic drain,
  input wire logic status_out_a_oe,
  input wire logic status_out_b_oe,
  input wire logic supply_good_n_oe,
  output logic status_out_a_i,
  output logic status_out_b_i,
  output logic supply_good_n_i,
  output logic bat_below_precond,
  output logic bat_at_reg,
  output logic eoc_current,
  output logic bat_below_recharge
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] lvl_q;
  // Pull-ups lift every released status pin to high.
  assign status_out_a_i = !status_out_a_oe;
  assign status_out_b_i = !status_out_b_oe;
  assign supply_good_n_i = !supply_good_n_oe;
  // Cell voltage climbs while current flows; a stall models a slow cell.
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      lvl_q <= 7'h00;
    else if (drain)
      lvl_q <= 7'h40;
    else if ((pass_enable || precondition_mode) && !stall && lvl_q != 7'h7f)
      lvl_q <= lvl_q + 7'h01;
  // Comparator results are taken from the upper four bits of the level.
  assign bat_below_precond = lvl_q[6:3] < 4'h3;
  assign bat_at_reg = lvl_q[6:3] >= 4'hc;
  assign eoc_current = lvl_q[6:3] == 4'hf;
  assign bat_below_recharge = lvl_q[6:3] < 4'ha;
endmodule

// ### sim/chg_ctrl_sva.sv
module chg_ctrl_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic supply_lockout,
  input wire logic temp_in_window,
  input wire logic current_set_pin,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic status_out_a_o,
  input wire logic status_out_a_oe,
  input wire logic status_out_b_o,
  input wire logic status_out_b_oe,
  input wire logic supply_good_n_o,
  input wire logic supply_good_n_oe,
  input wire logic pass_enable,
  input wire logic regulator_mode,
  input wire logic thermistor_bias_current,
  input wire logic temp_pulldown
);
  timeunit 1ns;
  timeprecision 1ns;
  // All checks run on the one clock and rest during reset.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  a_never_high: assert property (!status_out_a_o && !status_out_b_o
    && !supply_good_n_o)
    else $error("status pin driven high");
  a_temp_hold: assert property (!temp_in_window [*7] |-> !pass_enable)
    else $error("charging with temperature out of window");
  a_test_bias: assert property (regulator_mode |-> !thermistor_bias_current
    && temp_pulldown)
    else $error("bias or pull-down wrong in test mode");
  a_charge_bias: assert property (pass_enable |-> thermistor_bias_current)
    else $error("thermistor bias off while charging");
  a_charge_pull: assert property (pass_enable |-> !temp_pulldown)
    else $error("pull-down on while charging");
  a_test_pins: assert property (regulator_mode |-> status_out_a_oe && status_out_b_oe)
    else $error("test mode pins wrong");
  a_charge_pins: assert property (pass_enable |-> status_out_a_oe && !status_out_b_oe)
    else $error("charging pins wrong");
  a_lockout_wins: assert property (supply_lockout [*7] |-> !pass_enable
    && !status_out_a_oe && !status_out_b_oe && !supply_good_n_oe)
    else $error("lockout did not shut down");
  a_current_set_pin_open: assert property (current_set_pin [*7] |-> !pass_enable)
    else $error("charging with current set open");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  // Main scenarios reached.
  c_test: cover property (regulator_mode);
  c_done: cover property (status_out_b_oe && !status_out_a_oe);
  c_susp: cover property ($fell(pass_enable) && !temp_in_window);
endmodule

// ### sim/chg_ctrl_tb.sv
module chg_ctrl_tb
  import chg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic supply_lockout = 1, supply_above_bat = 0, supply_above_reg = 1, temp_in_window = 1;
  logic temp_test_level = 0, battery_present = 1, current_set_pin = 0, timer_enable_n = 0;
  logic stall = 0, drain = 0, status_out_a_i, status_out_b_i, supply_good_n_i;
  logic bat_below_precond, bat_at_reg, eoc_current, bat_below_recharge;
  logic status_out_a_o, status_out_a_oe, status_out_b_o, status_out_b_oe;
  logic supply_good_n_o, supply_good_n_oe, pass_enable, precondition_mode;
  logic regulator_mode, thermistor_bias_current, temp_pulldown;
  int fails = 0, samples_checked = 0, k, eoc_seen = 0;
  logic [31:0] t1, t2;
  // The clock toggles every half period and the slave's ready closes the bus.
  always #5 ref_clk = ~ref_clk;
  assign hready = hreadyout;
  // Counts cycles with end-of-charge current present while still charging.
  always @(posedge ref_clk)
  begin
    if (eoc_current && status_out_a_oe)
      eoc_seen <= eoc_seen + 1;
  end
  chg_ctrl #(.EOC_FILTER_CYCLES(20), .MS_CYCLES(10), .SAFETY_MS(50)) i_dut (.ref_clk, .rst,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .supply_lockout, .supply_above_bat, .supply_above_reg, .temp_in_window, .temp_test_level,
    .battery_present, .current_set_pin, .bat_below_precond, .bat_at_reg, .eoc_current,
    .bat_below_recharge, .timer_enable_n, .status_out_a_i, .status_out_b_i, .supply_good_n_i,
    .status_out_a_o, .status_out_a_oe, .status_out_b_o, .status_out_b_oe, .supply_good_n_o,
    .supply_good_n_oe, .pass_enable, .precondition_mode, .regulator_mode,
    .thermistor_bias_current, .temp_pulldown, .irq);
  chg_batt_model i_batt (.ref_clk, .rst, .pass_enable, .precondition_mode, .stall, .drain,
    .status_out_a_oe, .status_out_b_oe, .supply_good_n_oe, .status_out_a_i, .status_out_b_i,
    .supply_good_n_i, .bat_below_precond, .bat_at_reg, .eoc_current, .bat_below_recharge);
  // Expected open-drain enables {a, b, supply-good} for each state code.
  function automatic logic [2:0] exp_pins(input logic [3:0] s);
    case (s)
      4'h0: return 3'h0;
      4'h2, 4'h3, 4'h4: return 3'h5;
      4'h5: return 3'h3;
      4'h8: return 3'h7;
      default: return 3'h1;
    endcase
  endfunction
  // Compares one value and counts it.
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s exp %h seen %h", n, exp, seen);
    end
  endtask
  // One single AHB transfer; read data lands in rd.
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Polls the state field until it matches, then checks the pin encoding.
  task wait_st(input logic [3:0] s);
    k = 0;
    do
    begin
      ahb(1'b0, OFS_STATUS, 32'h0);
      k++;
    end
    while (rd[3:0] !== s && k < 400);
    chk("state", rd[3:0], s);
    chk("pins", {status_out_a_oe, status_out_b_oe, supply_good_n_oe},
        exp_pins(s));
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // A hang is cut short well beyond the expected run time.
  initial
  begin
    #900000;
    fails++;
    final_report();
  end
  // Main sequence: registers, charge cycle, faults, test mode, probing, lockout.
  initial
  begin
    void'($urandom(53001));
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    ahb(1'b0, OFS_INT_EN, 32'h0);
    chk("int_en", rd, 32'h0);
    repeat (4)
    begin
      t1 = $urandom;
      ahb(1'b1, OFS_INT_EN, t1);
      ahb(1'b0, OFS_INT_EN, 32'h0);
      chk("int_en", rd, {27'h0, t1[4:0]});
      ahb(1'b1, 8'h80, t1);
      ahb(1'b0, 8'h80, 32'h0);
      chk("unmapped", rd, 32'h0);
    end
    ahb(1'b1, OFS_INT_EN, 32'h2);
    supply_lockout <= 1'b0;
    supply_above_bat <= 1'b1;
    wait_st(4'h2);
    chk("precond", precondition_mode, 1'b1);
    wait_st(4'h3);
    chk("irq masked", irq, 1'b0);
    stall <= 1'b1;
    repeat (30) @(posedge ref_clk);
    temp_in_window <= 1'b0;
    wait_st(4'h6);
    chk("pass", pass_enable, 1'b0);
    chk("irq", irq, 1'b1);
    ahb(1'b0, OFS_TIMER, 32'h0);
    t1 = rd;
    repeat (60) @(posedge ref_clk);
    ahb(1'b0, OFS_TIMER, 32'h0);
    chk("held timer", rd, t1);
    ahb(1'b1, OFS_INT_CLR, 32'h1f);
    ahb(1'b0, OFS_INT_STAT, 32'h0);
    chk("int_stat", rd, 32'h0);
    chk("irq clear", irq, 1'b0);
    temp_in_window <= 1'b1;
    wait_st(4'h3);
    ahb(1'b0, OFS_TIMER, 32'h0);
    chk("resumed timer", rd - t1 <= 2, 1'b1);
    timer_enable_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    ahb(1'b0, OFS_TIMER, 32'h0);
    t1 = rd;
    repeat (60) @(posedge ref_clk);
    ahb(1'b0, OFS_TIMER, 32'h0);
    chk("timer off", rd, t1);
    ahb(1'b1, OFS_CTRL, 32'h2);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h2);
    timer_enable_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    ahb(1'b0, OFS_TIMER, 32'h0);
    t1 = rd;
    repeat (60) @(posedge ref_clk);
    ahb(1'b0, OFS_TIMER, 32'h0);
    chk("ctrl timer off", rd, t1);
    ahb(1'b1, OFS_CTRL, 32'h0);
    wait_st(4'h7);
    current_set_pin <= 1'b1;
    wait_st(4'h1);
    current_set_pin <= 1'b0;
    stall <= 1'b0;
    wait_st(4'h3);
    ahb(1'b0, OFS_TIMER, 32'h0);
    chk("timer cleared", rd <= 1, 1'b1);
    wait_st(4'h4);
    wait_st(4'h5);
    chk("eoc filter", eoc_seen >= 20 && eoc_seen < 30, 1'b1);
    drain <= 1'b1;
    @(posedge ref_clk);
    drain <= 1'b0;
    wait_st(4'h3);
    stall <= 1'b1;
    ahb(1'b1, OFS_CTRL, 32'h1);
    wait_st(4'h1);
    ahb(1'b1, OFS_CTRL, 32'h0);
    wait_st(4'h3);
    current_set_pin <= 1'b1;
    wait_st(4'h1);
    battery_present <= 1'b0;
    current_set_pin <= 1'b0;
    temp_test_level <= 1'b1;
    wait_st(4'h8);
    chk("test outs", {regulator_mode, thermistor_bias_current, temp_pulldown},
        3'h5);
    temp_test_level <= 1'b0;
    wait_st(4'h1);
    chk("standby outs", {thermistor_bias_current, temp_pulldown}, 2'h1);
    supply_above_reg <= 1'b0;
    t1 = 0;
    t2 = {31'h0, supply_good_n_oe};
    repeat (2500)
    begin
      @(posedge ref_clk);
      if (supply_good_n_oe !== t2[0])
        t1++;
      t2 = {31'h0, supply_good_n_oe};
    end
    chk("probe toggles", t1 > 1 && t1 < 4, 1'b1);
    supply_above_reg <= 1'b1;
    supply_lockout <= 1'b1;
    wait_st(4'h0);
    repeat (10) @(posedge ref_clk);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk("pin readback", rd[18:16], 3'h7);
    final_report();
  end
endmodule

bind chg_ctrl chg_ctrl_sva i_sva (.ref_clk, .rst, .supply_lockout, .temp_in_window,
  .current_set_pin, .hreadyout, .hresp, .status_out_a_o, .status_out_a_oe, .status_out_b_o,
  .status_out_b_oe, .supply_good_n_o, .supply_good_n_oe, .pass_enable, .regulator_mode,
  .thermistor_bias_current, .temp_pulldown);
